/* File: inc/fmte_pkg.sv */
package fmte_pkg;

    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] FMTE_INSTR_ADDR  = 8'h00;
    localparam logic [7:0] FMTE_CTRL_ADDR   = 8'h04;
    localparam logic [7:0] FMTE_STAT_ADDR   = 8'h08;
    localparam logic [7:0] FMTE_CCR_ADDR    = 8'h0c;
    localparam logic [7:0] FMTE_ER_ADDR     = 8'h10;
    localparam logic [7:0] FMTE_IER_ADDR    = 8'h14;
    localparam logic [7:0] FMTE_SR_ADDR     = 8'h18;
    localparam logic [7:0] FMTE_DATA_BASE   = 8'h40;
    localparam logic [7:0] FMTE_DATA_LAST   = 8'h7c;

    // ==================================================================
    // Wide float format: sign, 11-bit exponent, 32-bit mantissa
    localparam int FMTE_WIDE_W   = 44;
    localparam int FMTE_MANT_W   = 32;
    localparam int FMTE_EXP_W    = 11;
    localparam int FMTE_HI_W     = 12;
    localparam int FMTE_QUIET_BIT = 30;

    // ==================================================================
    // Condition code byte bit positions
    localparam int CCR_C  = 0;
    localparam int CCR_V  = 1;
    localparam int CCR_Z  = 2;
    localparam int CCR_N  = 3;
    localparam int CCR_I  = 4;

    // Exception status word bit positions
    localparam int ER_INX   = 0;
    localparam int ER_DZ    = 1;
    localparam int ER_UNF   = 2;
    localparam int ER_OVF   = 3;
    localparam int ER_INVALID_OP_FLAG = 4;
    localparam int ER_SIGNALING_NAN_FLAG  = 5;
    localparam int ER_NAN   = 6;
    localparam int ER_UNCOMPARABLE_TEST_FLAG  = 7;

    // Sticky exception word bit positions
    localparam int IER_SINX = 0;
    localparam int IER_SDZ  = 1;
    localparam int IER_SUNF = 2;
    localparam int IER_SOVF = 3;
    localparam int IER_STICKY_INVALID_OP_FLAG = 4;

    // Control register fields
    localparam int CTRL_EXTRA_LSB = 0;
    localparam int CTRL_LONG_ISR  = 16;

    // Status register bits
    localparam int STAT_BUSY    = 0;
    localparam int STAT_TAKEN   = 1;
    localparam int STAT_ILLEGAL = 2;

    // ==================================================================
    // Timing in oscillator cycles
    localparam int FMTE_BASE_CYC = 2;
    localparam int FMTE_TRAP_CYC = 10;

    // Priority mask level set on a long service routine
    localparam logic [1:0] FMTE_PRIO_LONG = 2'h3;
    localparam logic [7:0] FMTE_RST_BYTE  = 8'h00;

    // ==================================================================
    // Opcode patterns
    localparam logic [1:0]  OPC_ALU_CLASS  = 2'h2;
    localparam logic [3:0]  OPC_TST_SRC    = 4'h6;
    localparam logic [1:0]  OPC_COPY_SUB   = 2'h3;
    localparam logic [1:0]  OPC_TST_SUB    = 2'h0;
    localparam logic [17:0] OPC_TRAP_HIGH  = 18'h00000;
    localparam logic [3:0]  OPC_TRAP_LOW   = 4'h3;
    localparam logic [3:0]  OPC_TRAP_MID   = 4'h0;

    // Condition codes
    localparam logic [4:0] CC_GT  = 5'h00;
    localparam logic [4:0] CC_LT  = 5'h01;
    localparam logic [4:0] CC_GE  = 5'h02;
    localparam logic [4:0] CC_LE  = 5'h03;
    localparam logic [4:0] CC_GL  = 5'h04;
    localparam logic [4:0] CC_INF = 5'h05;
    localparam logic [4:0] CC_GLE = 5'h06;
    localparam logic [4:0] CC_OR  = 5'h07;
    localparam logic [4:0] CC_EQ  = 5'h08;
    localparam logic [4:0] CC_PL  = 5'h09;
    localparam logic [4:0] CC_ERR = 5'h0f;
    localparam logic [4:0] CC_NEG_LAST = 5'h19;
    localparam int         CC_NEG_BIT  = 4;

    typedef enum {OP_NONE, OP_COPY, OP_TEST, OP_TRAP} fmte_op_e;

    // Operand classification
    typedef struct packed {
        logic zero;
        logic neg;
        logic inf;
        logic nan;
        logic signaling_nan_flag;
    } fmte_class_s;

    // Condition evaluation result
    typedef struct packed {
        logic legal;
        logic truth;
        logic non_aware;
    } fmte_cond_s;

endpackage

/* File: design/fmte_core.sv */
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module fmte_core
    import fmte_pkg::*;
#(
    parameter int EXTRA_W = 8
)(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    // Execution events
    output logic             TRAP_TAKE,
    output logic             OP_DONE
);

    generate
        if (EXTRA_W < 1 || EXTRA_W > 16)
        begin : g_chk
            $error("EXTRA_W must lie in 1..16");
        end
    endgenerate

    // ==================================================================
    // Functions
    function automatic fmte_class_s classify(input logic [FMTE_WIDE_W-1:0] v);
        fmte_class_s c;
        logic        exp_max;
        logic        mant_zero;
        exp_max   = &v[FMTE_WIDE_W-2 -: FMTE_EXP_W];
        mant_zero = (v[FMTE_MANT_W-1:0] == '0);
        c.zero = (v[FMTE_WIDE_W-2:0] == '0);
        c.nan  = exp_max & ~mant_zero;
        c.inf  = exp_max & mant_zero;
        c.neg  = v[FMTE_WIDE_W-1] & ~c.nan;
        c.signaling_nan_flag = c.nan & ~v[FMTE_QUIET_BIT];
        return c;
    endfunction

    function automatic fmte_cond_s eval_cond(input logic [4:0] cc,
                                             input logic [7:0] condition_code_byte,
                                             input logic [7:0] er);
        fmte_cond_s r;
        logic       nan;
        logic       z;
        logic       n;
        logic       base;
        nan = er[ER_NAN];
        z   = condition_code_byte[CCR_Z];
        n   = condition_code_byte[CCR_N];
        r.legal     = 1'b1;
        r.non_aware = 1'b1;
        base        = 1'b0;
        unique case ({1'b0, cc[3:0]})
            CC_GT:  base = ~(nan | z | n);
            CC_LT:  base = ~(nan | z | ~n);
            CC_GE:  base = ~(nan | (n & ~z));
            CC_LE:  base = ~(nan | ~(n | z));
            CC_GL:  base = ~(nan | z);
            CC_INF: base = condition_code_byte[CCR_I];
            CC_GLE: base = ~nan;
            CC_OR:
            begin
                base        = ~nan;
                r.non_aware = 1'b0;
            end
            CC_EQ:
            begin
                base        = z;
                r.non_aware = 1'b0;
            end
            CC_PL:
            begin
                base        = ~n;
                r.non_aware = 1'b0;
            end
            CC_ERR:
            begin
                base = er[ER_UNCOMPARABLE_TEST_FLAG] | er[ER_SIGNALING_NAN_FLAG] | er[ER_INVALID_OP_FLAG]
                     | er[ER_OVF] | er[ER_UNF] | er[ER_DZ];
                r.non_aware = 1'b0;
                r.legal     = ~cc[CC_NEG_BIT];
            end
            default:
            begin
                r.legal     = 1'b0;
                r.non_aware = 1'b0;
            end
        endcase
        if (cc > CC_NEG_LAST)
            r.legal = 1'b0;
        r.truth = cc[CC_NEG_BIT] ? ~base : base;
        return r;
    endfunction

    // ==================================================================
    // Registers
    logic [FMTE_WIDE_W-1:0] dreg_q [8];
    logic [7:0]             ccr_q;
    logic [7:0]             er_q;
    logic [7:0]             ier_q;
    logic [1:0]             prio_q;
    logic [EXTRA_W-1:0]     extra_q;
    logic                   long_isr_q;
    logic                   taken_q;
    logic                   illegal_q;
    logic [31:0]            instr_q;
    fmte_op_e               op_q;
    logic                   busy_q;
    logic [EXTRA_W:0]       cnt_q;

    // Bus pipeline
    logic                   wr_pend_q;
    logic [7:0]             addr_q;
    logic                   addr_ok_q;
    logic                   hready_q;
    logic [31:0]            hrdata_q;
    logic                   hresp_q;
    logic                   trap_q;
    logic                   done_q;

    // ==================================================================
    // Decode of the instruction written by software
    fmte_op_e   op_d;
    fmte_cond_s cond_new;
    logic       cond_ok;

    // Full trap word first: it also matches a zero compare with an empty move field
    always_comb
    begin
        op_d = OP_NONE;
        if (HWDATA[31:14] == OPC_TRAP_HIGH && HWDATA[13]
            && HWDATA[7:4] == OPC_TRAP_MID && HWDATA[3:0] == OPC_TRAP_LOW)
            op_d = OP_TRAP;
        else if (HWDATA[13:12] == OPC_ALU_CLASS && HWDATA[11] && HWDATA[5:4] == OPC_COPY_SUB
                 && !HWDATA[3])
            op_d = OP_COPY;
        else if (HWDATA[13:12] == OPC_ALU_CLASS && HWDATA[11:8] == OPC_TST_SRC
                 && HWDATA[5:4] == OPC_TST_SUB && !HWDATA[3])
            op_d = OP_TEST;
    end

    assign cond_new = eval_cond(HWDATA[12:8], ccr_q, er_q);
    assign cond_ok  = cond_new.legal;

    // ==================================================================
    // AHB-Lite slave
    logic addr_phase;
    logic bus_wr;
    logic issue;

    assign addr_phase = HSEL & HTRANS[1] & HREADY;
    assign bus_wr     = wr_pend_q & addr_ok_q;
    assign issue      = bus_wr && addr_q == FMTE_INSTR_ADDR && !busy_q;

    function automatic logic mapped(input logic [7:0] a);
        return a == FMTE_INSTR_ADDR || a == FMTE_CTRL_ADDR || a == FMTE_STAT_ADDR
            || a == FMTE_CCR_ADDR || a == FMTE_ER_ADDR || a == FMTE_IER_ADDR
            || a == FMTE_SR_ADDR || (a >= FMTE_DATA_BASE && a <= FMTE_DATA_LAST);
    endfunction

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0]            r;
        logic [FMTE_WIDE_W-1:0] d;
        r = '0;
        d = dreg_q[a[5:3]];
        unique case (a)
            FMTE_INSTR_ADDR: r = instr_q;
            FMTE_CTRL_ADDR:
            begin
                r[CTRL_EXTRA_LSB +: EXTRA_W] = extra_q;
                r[CTRL_LONG_ISR]             = long_isr_q;
            end
            FMTE_STAT_ADDR:
            begin
                r[STAT_BUSY]    = busy_q;
                r[STAT_TAKEN]   = taken_q;
                r[STAT_ILLEGAL] = illegal_q;
            end
            FMTE_CCR_ADDR:   r[7:0] = ccr_q;
            FMTE_ER_ADDR:    r[7:0] = er_q;
            FMTE_IER_ADDR:   r[7:0] = ier_q;
            FMTE_SR_ADDR:    r[1:0] = prio_q;
            default:
            begin
                if (a >= FMTE_DATA_BASE && a <= FMTE_DATA_LAST)
                    r = a[2] ? {20'h00000, d[FMTE_WIDE_W-1 -: FMTE_HI_W]}
                             : d[FMTE_MANT_W-1:0];
            end
        endcase
        return r;
    endfunction

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            addr_ok_q <= 1'b0;
            hrdata_q  <= 32'h00000000;
            hready_q  <= 1'b1;
            hresp_q   <= 1'b0;
        end
        else
        begin
            hready_q  <= 1'b1;
            hresp_q   <= 1'b0;
            wr_pend_q <= addr_phase & HWRITE;
            if (addr_phase)
            begin
                addr_q    <= HADDR[7:0];
                addr_ok_q <= (HADDR[31:8] == '0) && mapped(HADDR[7:0]);
                hrdata_q  <= (HADDR[31:8] == '0) ? read_mux(HADDR[7:0]) : 32'h00000000;
            end
        end
    end

    // ==================================================================
    // Configuration registers
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            extra_q    <= '0;
            long_isr_q <= 1'b0;
        end
        else if (bus_wr && addr_q == FMTE_CTRL_ADDR)
        begin
            extra_q    <= HWDATA[CTRL_EXTRA_LSB +: EXTRA_W];
            long_isr_q <= HWDATA[CTRL_LONG_ISR];
        end
    end

    // ==================================================================
    // Sequencer
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            busy_q    <= 1'b0;
            cnt_q     <= '0;
            op_q      <= OP_NONE;
            instr_q   <= 32'h00000000;
            illegal_q <= 1'b0;
        end
        else if (issue)
        begin
            instr_q <= HWDATA;
            if (op_d == OP_NONE || (op_d == OP_TRAP && !cond_ok))
            begin
                illegal_q <= 1'b1;
                op_q      <= OP_NONE;
            end
            else
            begin
                illegal_q <= 1'b0;
                op_q      <= op_d;
                busy_q    <= 1'b1;
                if (op_d == OP_TRAP)
                    cnt_q <= (EXTRA_W+1)'(FMTE_TRAP_CYC - 1);
                else
                    cnt_q <= (EXTRA_W+1)'(FMTE_BASE_CYC - 1)
                           + {1'b0, extra_q};
            end
        end
        else if (busy_q)
        begin
            if (cnt_q == '0)
                busy_q <= 1'b0;
            else
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // ==================================================================
    // Execution results
    logic                   finish;
    logic [2:0]             src_sel;
    logic [2:0]             dst_sel;
    fmte_class_s            cls;
    fmte_cond_s             cond;
    logic [7:0]             er_new;
    logic                   raise_uncomparable_test_flag;

    assign finish     = busy_q && cnt_q == '0;
    assign src_sel    = (op_q == OP_COPY) ? instr_q[10:8] : instr_q[2:0];
    assign dst_sel    = instr_q[2:0];
    assign cls        = classify(dreg_q[src_sel]);
    assign cond       = eval_cond(instr_q[12:8], ccr_q, er_q);
    assign raise_uncomparable_test_flag = cond.non_aware & er_q[ER_NAN];

    always_comb
    begin
        er_new           = 8'h00;
        er_new[ER_SIGNALING_NAN_FLAG]  = cls.signaling_nan_flag;
        er_new[ER_NAN]   = cls.nan;
    end

    // Data registers
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            for (int i = 0; i < 8; i++)
                dreg_q[i] <= '0;
        end
        else if (finish && op_q == OP_COPY)
            dreg_q[dst_sel] <= dreg_q[src_sel];
        else if (bus_wr && addr_q >= FMTE_DATA_BASE && addr_q <= FMTE_DATA_LAST)
        begin
            if (addr_q[2])
                dreg_q[addr_q[5:3]][FMTE_WIDE_W-1 -: FMTE_HI_W] <= HWDATA[FMTE_HI_W-1:0];
            else
                dreg_q[addr_q[5:3]][FMTE_MANT_W-1:0] <= HWDATA;
        end
    end

    // Condition code byte
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            ccr_q <= FMTE_RST_BYTE;
        else if (finish && op_q != OP_TRAP)
        begin
            ccr_q[CCR_Z] <= cls.zero;
            ccr_q[CCR_N] <= cls.neg;
            ccr_q[CCR_I] <= cls.inf;
        end
        else if (bus_wr && addr_q == FMTE_CCR_ADDR && !finish)
            ccr_q <= HWDATA[7:0];
    end

    // Exception status word
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            er_q <= FMTE_RST_BYTE;
        else if (finish && op_q != OP_TRAP)
            er_q <= er_new;
        else if (finish && raise_uncomparable_test_flag)
            er_q[ER_UNCOMPARABLE_TEST_FLAG] <= 1'b1;
        else if (bus_wr && addr_q == FMTE_ER_ADDR && !finish)
            er_q <= HWDATA[7:0];
    end

    // Sticky exception word
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            ier_q <= FMTE_RST_BYTE;
        else if (finish && op_q != OP_TRAP)
        begin
            ier_q[IER_STICKY_INVALID_OP_FLAG] <= ier_q[IER_STICKY_INVALID_OP_FLAG] | er_new[ER_INVALID_OP_FLAG]
                             | er_new[ER_SIGNALING_NAN_FLAG] | er_new[ER_UNCOMPARABLE_TEST_FLAG];
            ier_q[IER_SINX] <= ier_q[IER_SINX] | er_new[ER_INX];
            ier_q[IER_SDZ]  <= ier_q[IER_SDZ]  | er_new[ER_DZ];
            ier_q[IER_SUNF] <= ier_q[IER_SUNF] | er_new[ER_UNF];
            ier_q[IER_SOVF] <= ier_q[IER_SOVF] | er_new[ER_OVF];
        end
        else if (finish && raise_uncomparable_test_flag)
            ier_q[IER_STICKY_INVALID_OP_FLAG] <= 1'b1;
        else if (bus_wr && addr_q == FMTE_IER_ADDR && !finish)
            ier_q <= HWDATA[7:0];
    end

    // Trap outcome and priority mask
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            prio_q  <= 2'h0;
            taken_q <= 1'b0;
            trap_q  <= 1'b0;
        end
        else
        begin
            trap_q <= finish && op_q == OP_TRAP && cond.truth;
            if (finish && op_q == OP_TRAP)
            begin
                taken_q <= cond.truth;
                if (cond.truth && long_isr_q)
                    prio_q <= FMTE_PRIO_LONG;
            end
            else if (bus_wr && addr_q == FMTE_SR_ADDR)
                prio_q <= HWDATA[1:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            done_q <= 1'b0;
        else
            done_q <= finish;
    end

    assign HREADYOUT = hready_q;
    assign HRDATA    = hrdata_q;
    assign HRESP     = hresp_q;
    assign TRAP_TAKE = trap_q;
    assign OP_DONE   = done_q;

endmodule

/* File: tb/fmte_chk.sv */
`timescale 1ns/1ps
module fmte_chk
    import fmte_pkg::*;
#(
    parameter int EXTRA_W = 8
)(
    // Clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    // Bus
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [2:0]  HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic [31:0] HRDATA,
    input wire logic        HRESP,
    // Events
    input wire logic        TRAP_TAKE,
    input wire logic        OP_DONE
);
    // ====================
    // Issue tracking
    logic               wr_q, pend_q, trap_q;
    logic [7:0]         adr_q, cnt_q;
    logic [EXTRA_W-1:0] ext_q;
    wire  [4:0]         cc = HWDATA[12:8];
    wire ins = wr_q && adr_q == FMTE_INSTR_ADDR;
    wire ok = cc <= CC_PL || cc == CC_ERR || (cc[CC_NEG_BIT] && cc <= CC_NEG_LAST);
    wire trp = ins && HWDATA[31:13] == 19'h1 && HWDATA[7:0] == 8'h03;
    wire alu = ins && HWDATA[13:12] == 2'b10 && ((HWDATA[11] && HWDATA[5:3] == 3'b110)
               || (HWDATA[11:8] == 4'h6 && HWDATA[5:3] == 3'h0));

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            wr_q  <= 1'b0;
            adr_q <= 8'h00;
            ext_q <= '0;
        end
        else
        begin
            wr_q  <= HSEL && HTRANS[1] && HREADY && HWRITE;
            adr_q <= HADDR[31:8] == 24'h0 ? HADDR[7:0] : 8'hff;
            if (wr_q && adr_q == FMTE_CTRL_ADDR)
                ext_q <= HWDATA[EXTRA_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pend_q <= 1'b0;
            trap_q <= 1'b0;
            cnt_q  <= 8'h00;
        end
        else if ((trp && ok) || alu)
        begin
            pend_q <= 1'b1;
            trap_q <= trp;
            cnt_q  <= 8'h00;
        end
        else
        begin
            pend_q <= pend_q && !OP_DONE;
            cnt_q  <= cnt_q + 8'h01;
        end
    end

    // ====================
    // Properties
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    property p_trap_time;
        trp && ok |-> ##11 (OP_DONE && cnt_q == 8'(FMTE_TRAP_CYC));
    endproperty
    property p_alu_time;
        OP_DONE && pend_q && !trap_q |-> cnt_q == ext_q + 8'(FMTE_BASE_CYC);
    endproperty
    property p_take_done;
        TRAP_TAKE |-> OP_DONE && trap_q;
    endproperty
    property p_alu_take;
        alu |=> !TRAP_TAKE [*4];
    endproperty
    property p_pulse;
        OP_DONE |=> !OP_DONE;
    endproperty
    property p_pend;
        OP_DONE |-> pend_q;
    endproperty
    property p_bad;
        trp && !ok |=> !OP_DONE [*8];
    endproperty
    property p_bus;
        HREADYOUT && !HRESP;
    endproperty
    a_trap_time: assert property (p_trap_time) else $error("trap length wrong");
    a_alu_time: assert property (p_alu_time) else $error("op length wrong");
    a_take_done: assert property (p_take_done) else $error("stray trap");
    a_alu_take: assert property (p_alu_take) else $error("trap on move");
    a_pulse: assert property (p_pulse) else $error("done too long");
    a_pend: assert property (p_pend) else $error("done without op");
    a_bad: assert property (p_bad) else $error("illegal code ran");
    a_bus: assert property (p_bus) else $error("bus wait or error");
    c_take: cover property (TRAP_TAKE);
    c_alu: cover property (alu ##[3:6] OP_DONE);
    c_bad: cover property (trp && !ok);
endmodule

bind fmte_core fmte_chk #(.EXTRA_W(EXTRA_W)) fmte_chk_i (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
    .HRESP(HRESP), .TRAP_TAKE(TRAP_TAKE), .OP_DONE(OP_DONE));

/* File: tb/test_float_move_test_trap_exec.sv */
`timescale 1ns/1ps
module test_float_move_test_trap_exec;
    import fmte_pkg::*;
    logic        SYS_CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, tk = 1'b0;
    logic [1:0]  HTRANS = 2'h0, sm;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, sv;
    logic        HREADYOUT, HRESP, TRAP_TAKE, OP_DONE;
    logic [7:0]  cm, em, im;
    logic [43:0] ops [6];
    logic [39:0] eq [$];
    logic        tq [$];
    int          n_fail = 0, cmp_count = 0;
    event        got;

    always #2 SYS_CLK = ~SYS_CLK;

    fmte_core fmte_core_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .TRAP_TAKE(TRAP_TAKE),
        .OP_DONE(OP_DONE));

    // ====================
    // Bus and checking
    task automatic chk(input string s, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        sv = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, {24'h0, a}, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        eq.push_back({a, e});
        bus(1'b0, {24'h0, a}, $urandom);
        -> got;
    endtask
    task automatic op(input logic [31:0] w, input logic t);
        int k;
        tq.push_back(t);
        wr(FMTE_INSTR_ADDR, w);
        for (k = 0; k < 40 && OP_DONE !== 1'b1; k++) @(posedge SYS_CLK);
        if (k == 40)
            n_fail++;
        @(posedge SYS_CLK);
    endtask
    task automatic dat(input logic w, input logic [2:0] n, input logic [43:0] v);
        if (w)
            wr({2'b01, n, 3'h0}, v[31:0]);
        else
            rd({2'b01, n, 3'h0}, v[31:0]);
        if (w)
            wr({2'b01, n, 3'h4}, {20'h0, v[43:32]});
        else
            rd({2'b01, n, 3'h4}, {20'h0, v[43:32]});
    endtask
    always
    begin
        @(got);
        chk($sformatf("read %h", eq[0][39:32]), sv, eq[0][31:0]);
        void'(eq.pop_front());
    end
    always @(posedge SYS_CLK)
        if (OP_DONE === 1'b1)
            chk("trap take", {31'h0, TRAP_TAKE}, {31'h0, tq.pop_front()});

    // ====================
    // Scenarios
    task automatic alu(input logic [43:0] v, input logic tst);
        logic [2:0] s, d;
        logic       e1, nan, sn;
        s = 3'($urandom);
        d = s + 3'($urandom % 7) + 3'h1;
        e1 = &v[42:32];
        nan = e1 && v[31:0] != 0;
        sn = nan && !v[FMTE_QUIET_BIT];
        cm = {3'h7, e1 && !nan, v[43] && !nan, v[42:0] == 0, 2'h3};
        em = {1'b0, nan, sn, 5'h0};
        im = {3'h0, sn, 4'h0};
        dat(1'b1, s, v);
        dat(1'b1, d, 44'h5a5);
        wr(FMTE_CTRL_ADDR, $urandom % 4);
        wr(FMTE_CCR_ADDR, 32'he3);
        wr(FMTE_ER_ADDR, 32'h9f);
        wr(FMTE_IER_ADDR, 32'h0);
        if (tst)
            // Nonzero move field keeps the word apart from the trap encoding
            op({18'h1, 6'b100110, 2'($urandom), 3'h0, s}, 1'b0);
        else
            op({18'h0, 3'b101, s, 2'($urandom), 3'b110, d}, 1'b0);
        dat(1'b0, d, tst ? 44'h5a5 : v);
        rd(FMTE_CCR_ADDR, 32'(cm));
        rd(FMTE_ER_ADDR, 32'(em));
        rd(FMTE_IER_ADDR, 32'(im));
    endtask
    task automatic traps(input logic lng);
        logic [15:0] b;
        logic [4:0]  cc;
        logic        t, z, n, nn;
        wr(FMTE_CTRL_ADDR, {15'h0, lng, 16'h0});
        wr(FMTE_SR_ADDR, 32'h0);
        sm = 2'h0;
        z = cm[CCR_Z];
        n = cm[CCR_N];
        for (int j = 0; j < 32; j++)
        begin
            cc = 5'(j);
            nn = em[ER_NAN];
            b = {|(em & 8'hbe), 5'h0, !n, z, !nn, !nn, cm[CCR_I], !(nn | z),
                 !(nn | !(n | z)), !(nn | (n & !z)), !(nn | z | !n), !(nn | z | n)};
            t = cc[4] ^ b[cc[3:0]];
            if (cc > CC_NEG_LAST || (cc[3:0] > CC_PL[3:0] && cc != CC_ERR))
            begin
                wr(FMTE_INSTR_ADDR, {18'h0, 1'b1, cc, 8'h03});
                repeat (12) @(posedge SYS_CLK);
                rd(FMTE_STAT_ADDR, {29'h0, 1'b1, tk, 1'b0});
                continue;
            end
            op({18'h0, 1'b1, cc, 8'h03}, t);
            tk = t;
            if (nn && cc[3:0] <= CC_GLE[3:0])
            begin
                em[ER_UNCOMPARABLE_TEST_FLAG] = 1'b1;
                im[IER_STICKY_INVALID_OP_FLAG] = 1'b1;
            end
            if (t && lng)
                sm = FMTE_PRIO_LONG;
            rd(FMTE_CCR_ADDR, 32'(cm));
            rd(FMTE_ER_ADDR, 32'(em));
            rd(FMTE_IER_ADDR, 32'(im));
            rd(FMTE_SR_ADDR, 32'(sm));
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'hfd61));
        ops = '{{1'b0, 11'h3ff, $urandom}, {1'b1, 11'h401, $urandom}, 44'h0,
                {1'b1, 11'h7ff, 32'h0}, {1'b0, 11'h7ff, 32'h4000_0001}, {1'b1, 11'h7ff, 32'h5}};
        repeat (8) @(posedge SYS_CLK);
        RESET <= 1'b0;
        rd(FMTE_CCR_ADDR, 32'h0);
        rd(FMTE_STAT_ADDR, 32'h0);
        rd(8'h20, 32'h0);
        $display("test reset done");
        foreach (ops[i])
        begin
            alu(ops[i], 1'b0);
            alu(ops[i], 1'b1);
        end
        $display("test copy and compare done");
        for (int k = 0; k < 4; k++)
        begin
            alu(ops[k + 2], 1'b1);
            traps(k[0]);
        end
        $display("test traps done");
        close_out();
    end
endmodule
